// *** rtl/rcm_defs.svh ***
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the reference clock control block
`ifndef RCM_DEFS_SVH
`define RCM_DEFS_SVH

// Register offsets
`define RCM_OFS_REF_INPUT_CTRL   8'h11
`define RCM_OFS_BAND_CTRL        8'h12
`define RCM_OFS_LOOP_TUNING      8'h14
`define RCM_OFS_DIVIDER_CTRL     8'h15
`define RCM_OFS_STATUS_LOCK      8'h16
`define RCM_OFS_STATUS_BAND      8'h17

// Reset values
`define RCM_RST_REF_INPUT_CTRL   8'h5F
`define RCM_RST_BAND_CTRL        8'h00
`define RCM_RST_LOOP_TUNING      8'hE7
`define RCM_RST_DIVIDER_CTRL     8'hC9

// Reference input control fields
`define RCM_BIT_DUTY_FIX         7
`define RCM_BIT_REF_RSVD         6
`define RCM_BIT_CROSS_ADJ        5
`define RCM_CROSS_MSB            4
// Band control fields
`define RCM_BIT_MULT_EN          7
`define RCM_BIT_MANUAL_SEL       6
`define RCM_BAND_MSB             5
// Loop tuning fields
`define RCM_LFW_MSB              7
`define RCM_LFW_LSB              5
`define RCM_PUMP_MSB             4
// Divider control fields
`define RCM_LCR_MSB              7
`define RCM_LCR_LSB              6
`define RCM_BIT_LOOP_CROSS       4
`define RCM_OSC_MSB              3
`define RCM_OSC_LSB              2
`define RCM_LOOP_MSB             1
// Status fields
`define RCM_BIT_LOCK             7

// Timing: settle time per band trial, in ns, and its count at 100 MHz
`define RCM_CLK_PERIOD_NS        10
`define RCM_SETTLE_NS            200
`define RCM_SETTLE_CYC           \
    ((`RCM_SETTLE_NS + `RCM_CLK_PERIOD_NS - 1) / `RCM_CLK_PERIOD_NS)

`endif

// *** rtl/rcm_pkg.sv ***
// Types shared by the reference clock multiplier control block
// Assumes nothing of its surroundings
package rcm_pkg;
    typedef logic [5:0] rcm_band_t;
    typedef enum logic [3:0]
    {
        RCM_OFF    = 4'h1,
        RCM_SEARCH = 4'h2,
        RCM_SETTLE = 4'h4,
        RCM_LOCKED = 4'h8
    } rcm_state_e;
endpackage

// *** rtl/rcm_ratio_div.sv ***
// Programmable power-of-two divider for the multiplier logic clock
// Assumes a synchronous reset and a two-bit code from a register
`timescale 1ns/10ps
`default_nettype none
module rcm_ratio_div
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // Ratio code: 00 -> 2, 01 -> 4, 10 -> 8, 11 -> 16
    input  wire logic [1:0] ratio_code,
    // Divided-clock tick, one cycle per period
    output logic            tick
);
    logic [3:0] cnt_q;
    logic [3:0] last;

    // Terminal count from the ratio code; five bits so code 11 reaches 16
    // ratio 2, 4, 8, 16
    assign last = 4'((5'h02 << ratio_code) - 5'h01);

    // Free running counter, restarted at terminal count
    always_ff @(posedge core_clk)
    begin
        if (srst || cnt_q >= last)
        begin
            cnt_q <= 4'h0;
        end
        else
        begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Tick flop
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            tick <= 1'b0;
        end
        else
        begin
            tick <= (cnt_q >= last);
        end
    end
endmodule
`default_nettype wire

// *** rtl/rcm_ctrl.sv ***
// Reference clock receiver and clock multiplier control registers
// Assumes a synchronous register port and analog lock and tune inputs
// Operation
// - Bit 7 of reference control enables duty-cycle correction, resets off
// - Bit 5 of reference control enables crosspoint adjustment, resets off
// - Five-bit two's-complement crosspoint level, 01111 highest, 10000 lowest
// - Band control bit 7 enables the multiplier, off after reset
// - Band control bit 6: zero automatic band select, one manual
// - Manual six-bit band code picks one of 64 oscillator bands
// - Loop tuning bits 7:5 select filter bandwidth, reset all ones
// - Loop tuning bits 4:0 set pump current, reset 00111
// - Divider bits 7:6 divide the core clock for the logic clock tick by 2, 4, 8 or 16
// - Divider bit 4 enables loop divider crosspoint control, resets zero
// - Divider bits 3:2 give oscillator ratio 1, 2, 4, 4
// - Divider bits 1:0 give sample-to-reference ratio 2, 4, 8, 16
// - Read-only status bit 7 reports the multiplier locked
// - Read-only six-bit value reports the selected band
`timescale 1ns/10ps
`default_nettype none
`include "rcm_defs.svh"
module rcm_ctrl
#(
    parameter int SETTLE_CYC = `RCM_SETTLE_CYC
)
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // Register port
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Analog loop feedback
    input  wire logic       loop_locked,
    input  wire logic       tune_too_low,
    // Reference receiver controls
    output logic            ref_duty_fix_en,
    output logic            ref_cross_adjust_en,
    output logic      [4:0] ref_cross_level,
    // Multiplier controls
    output logic            mult_en,
    output logic      [5:0] band_sel,
    output logic      [2:0] loop_filter_width,
    output logic      [4:0] pump_current_code,
    output logic      [1:0] logic_clock_ratio,
    output logic            loop_cross_en,
    output logic      [1:0] oscillator_ratio_select,
    output logic      [1:0] loop_ratio_select,
    // Status
    output logic            mult_locked
);
    logic [7:0]         ref_ctrl_q;
    logic [7:0]         band_ctrl_q;
    logic [7:0]         tuning_q;
    logic [7:0]         divider_q;
    rcm_pkg::rcm_state_e state_q;
    rcm_pkg::rcm_band_t  auto_band_q;
    logic [15:0]        settle_q;
    logic               logic_tick;
    logic               manual;

    // Address match helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    assign manual = band_ctrl_q[`RCM_BIT_MANUAL_SEL];

    // Reference input control register
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ref_ctrl_q <= `RCM_RST_REF_INPUT_CTRL;
        end
        else if (reg_wr && hit(reg_addr, `RCM_OFS_REF_INPUT_CTRL))
        begin
            ref_ctrl_q <= reg_wdata;
        end
    end

    // Band control register
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            band_ctrl_q <= `RCM_RST_BAND_CTRL;
        end
        else if (reg_wr && hit(reg_addr, `RCM_OFS_BAND_CTRL))
        begin
            band_ctrl_q <= reg_wdata;
        end
    end

    // Loop tuning register
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            tuning_q <= `RCM_RST_LOOP_TUNING;
        end
        else if (reg_wr && hit(reg_addr, `RCM_OFS_LOOP_TUNING))
        begin
            tuning_q <= reg_wdata;
        end
    end

    // Divider control register
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            divider_q <= `RCM_RST_DIVIDER_CTRL;
        end
        else if (reg_wr && hit(reg_addr, `RCM_OFS_DIVIDER_CTRL))
        begin
            divider_q <= reg_wdata;
        end
    end

    rcm_ratio_div u_div
    (
        .core_clk   (core_clk),
        .srst       (srst),
        .ratio_code (divider_q[`RCM_LCR_MSB:`RCM_LCR_LSB]),
        .tick       (logic_tick)
    );

    // Band search state; forced to off while disabled, otherwise steps only on divided logic clock ticks
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_q     <= rcm_pkg::RCM_OFF;
            auto_band_q <= 6'h00;
            settle_q    <= 16'h0000;
        end
        else if (!band_ctrl_q[`RCM_BIT_MULT_EN])
        begin
            state_q     <= rcm_pkg::RCM_OFF;
            auto_band_q <= 6'h00;
            settle_q    <= 16'h0000;
        end
        else if (logic_tick)
        begin
            case (state_q)
                rcm_pkg::RCM_OFF:
                begin
                    state_q  <= rcm_pkg::RCM_SETTLE;
                    settle_q <= 16'h0000;
                end
                rcm_pkg::RCM_SEARCH:
                begin
                    if (!manual && tune_too_low && auto_band_q != 6'h3F)
                    begin
                        auto_band_q <= auto_band_q + 6'h01;
                    end
                    state_q  <= rcm_pkg::RCM_SETTLE;
                    settle_q <= 16'h0000;
                end
                rcm_pkg::RCM_SETTLE:
                begin
                    if (settle_q >= 16'(SETTLE_CYC - 1))
                    begin
                        state_q <= loop_locked ? rcm_pkg::RCM_LOCKED
                                               : rcm_pkg::RCM_SEARCH;
                    end
                    else
                    begin
                        settle_q <= settle_q + 16'h0001;
                    end
                end
                rcm_pkg::RCM_LOCKED:
                begin
                    if (!loop_locked)
                    begin
                        state_q <= rcm_pkg::RCM_SEARCH;
                    end
                end
                default:
                begin
                    state_q <= rcm_pkg::RCM_OFF;
                end
            endcase
        end
    end

    // Control outputs driven from the stored fields
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ref_duty_fix_en         <= 1'b0;
            ref_cross_adjust_en     <= 1'b0;
            ref_cross_level         <= 5'h1F;
            mult_en                 <= 1'b0;
            band_sel                <= 6'h00;
            loop_filter_width       <= 3'h7;
            pump_current_code       <= 5'h07;
            logic_clock_ratio       <= 2'h3;
            loop_cross_en           <= 1'b0;
            oscillator_ratio_select <= 2'h2;
            loop_ratio_select       <= 2'h1;
            mult_locked             <= 1'b0;
        end
        else
        begin
            ref_duty_fix_en         <= ref_ctrl_q[`RCM_BIT_DUTY_FIX];
            ref_cross_adjust_en     <= ref_ctrl_q[`RCM_BIT_CROSS_ADJ];
            ref_cross_level         <= ref_ctrl_q[`RCM_CROSS_MSB:0];
            mult_en                 <= band_ctrl_q[`RCM_BIT_MULT_EN];
            band_sel                <= manual ? band_ctrl_q[`RCM_BAND_MSB:0]
                                              : auto_band_q;
            loop_filter_width       <= tuning_q[`RCM_LFW_MSB:`RCM_LFW_LSB];
            pump_current_code       <= tuning_q[`RCM_PUMP_MSB:0];
            logic_clock_ratio       <= divider_q[`RCM_LCR_MSB:`RCM_LCR_LSB];
            loop_cross_en           <= divider_q[`RCM_BIT_LOOP_CROSS];
            oscillator_ratio_select <= divider_q[`RCM_OSC_MSB:`RCM_OSC_LSB];
            loop_ratio_select       <= divider_q[`RCM_LOOP_MSB:0];
            mult_locked             <= (state_q == rcm_pkg::RCM_LOCKED);
        end
    end

    // Read data; unmapped offsets read zero
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            if (hit(reg_addr, `RCM_OFS_REF_INPUT_CTRL))
            begin
                reg_rdata <= ref_ctrl_q;
            end
            else if (hit(reg_addr, `RCM_OFS_BAND_CTRL))
            begin
                reg_rdata <= band_ctrl_q;
            end
            else if (hit(reg_addr, `RCM_OFS_LOOP_TUNING))
            begin
                reg_rdata <= tuning_q;
            end
            else if (hit(reg_addr, `RCM_OFS_DIVIDER_CTRL))
            begin
                reg_rdata <= {divider_q[7:6], 1'b0, divider_q[4:0]};
            end
            else if (hit(reg_addr, `RCM_OFS_STATUS_LOCK))
            begin
                reg_rdata <= {mult_locked, 7'h00};
            end
            else if (hit(reg_addr, `RCM_OFS_STATUS_BAND))
            begin
                reg_rdata <= {2'h0, band_sel};
            end
            else
            begin
                reg_rdata <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// *** test/rcm_ctrl_asserts.sv ***
// Concurrent checks on the register port and field outputs
// Assumes binding to rcm_ctrl with one clock and a synchronous reset
`timescale 1ns/10ps
`default_nettype none
module rcm_ctrl_asserts
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       srst,
    // Register port
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Analog feedback
    input wire logic       loop_locked,
    input wire logic       tune_too_low,
    // Controls and status
    input wire logic       ref_duty_fix_en,
    input wire logic       ref_cross_adjust_en,
    input wire logic [4:0] ref_cross_level,
    input wire logic       mult_en,
    input wire logic [5:0] band_sel,
    input wire logic [2:0] loop_filter_width,
    input wire logic [4:0] pump_current_code,
    input wire logic [1:0] logic_clock_ratio,
    input wire logic       loop_cross_en,
    input wire logic [1:0] oscillator_ratio_select,
    input wire logic [1:0] loop_ratio_select,
    input wire logic       mult_locked
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // Write strobes decoded per register
    wire w11 = reg_wr && reg_addr == 8'h11;
    wire w12 = reg_wr && reg_addr == 8'h12;
    wire w14 = reg_wr && reg_addr == 8'h14;
    wire w15 = reg_wr && reg_addr == 8'h15;
    chk_ref_fields: assert property (
        w11 |=> ##1 {ref_duty_fix_en, ref_cross_adjust_en, ref_cross_level}
            == {$past(reg_wdata[7], 2), $past(reg_wdata[5:0], 2)})
        else $error("reference fields differ from write");
    chk_mult_enable: assert property (
        w12 |=> ##1 mult_en == $past(reg_wdata[7], 2))
        else $error("multiplier enable differs from write");
    chk_manual_band: assert property (
        w12 && reg_wdata[6] |=> ##1 band_sel == $past(reg_wdata[5:0], 2))
        else $error("manual band not applied");
    chk_loop_tuning: assert property (
        w14 |=> ##1 {loop_filter_width, pump_current_code}
            == $past(reg_wdata, 2))
        else $error("loop tuning fields differ from write");
    chk_divider_fields: assert property (
        w15 |=> ##1 {logic_clock_ratio, loop_cross_en,
            oscillator_ratio_select, loop_ratio_select}
            == {$past(reg_wdata[7:6], 2), $past(reg_wdata[4:0], 2)})
        else $error("divider fields differ from write");
    chk_reset_values: assert property (
        @(posedge core_clk) disable iff (1'b0) srst ##1 srst |=>
        {ref_duty_fix_en, ref_cross_adjust_en, ref_cross_level, mult_en,
            loop_filter_width, pump_current_code, logic_clock_ratio,
            loop_cross_en, oscillator_ratio_select, loop_ratio_select,
            mult_locked, reg_rdata} == {1'h0, 1'h0, 5'h1F, 1'h0, 3'h7,
            5'h07, 2'h3, 1'h0, 2'h2, 2'h1, 1'h0, 8'h00})
        else $error("outputs not at reset values");
    chk_unmapped_read: assert property (
        reg_rd && (reg_addr == 8'h13 || reg_addr > 8'h17
            || reg_addr < 8'h11) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_gap_bit_zero: assert property (
        reg_rd && reg_addr == 8'h15 |=> !reg_rdata[5])
        else $error("divider bit 5 reads one");
    chk_rdata_hold: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    chk_lock_enable: assert property (
        $rose(mult_locked) |-> $past(mult_en, 1) && $past(loop_locked, 2))
        else $error("lock raised while disabled or unlocked");
endmodule
bind rcm_ctrl rcm_ctrl_asserts u_chk (.core_clk(core_clk), .srst(srst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .loop_locked(loop_locked), .tune_too_low(tune_too_low),
    .ref_duty_fix_en(ref_duty_fix_en),
    .ref_cross_adjust_en(ref_cross_adjust_en),
    .ref_cross_level(ref_cross_level), .mult_en(mult_en),
    .band_sel(band_sel), .loop_filter_width(loop_filter_width),
    .pump_current_code(pump_current_code),
    .logic_clock_ratio(logic_clock_ratio), .loop_cross_en(loop_cross_en),
    .oscillator_ratio_select(oscillator_ratio_select),
    .loop_ratio_select(loop_ratio_select), .mult_locked(mult_locked));
`default_nettype wire

// *** test/rcm_loop_model.sv ***
// Behavioural analog loop: locks only on one target band
// Assumes the control block's enable and band outputs
`timescale 1ns/10ps
`default_nettype none
module rcm_loop_model
#(
    parameter logic [5:0] TARGET = 6'h05
)
(
    // Clock
    input  wire logic       core_clk,
    // Loop controls and a lock spoiler from the bench
    input  wire logic       mult_en,
    input  wire logic [5:0] band_sel,
    input  wire logic       lock_block,
    // Feedback
    output logic            loop_locked,
    output logic            tune_too_low
);
    // Lock and tune hints follow the selected band one cycle later
    always_ff @(posedge core_clk)
    begin
        loop_locked  <= mult_en && band_sel == TARGET && !lock_block;
        tune_too_low <= band_sel < TARGET;
    end
endmodule
`default_nettype wire

// *** test/test_ref_clock_multiplier_control.sv ***
// Self-checking bench for the multiplier control registers
// Assumes rcm_ctrl and the loop model; 100 MHz core clock
`timescale 1ns/10ps
`default_nettype none
module test_ref_clock_multiplier_control;
    logic       core_clk   = 1'b0;
    logic       srst       = 1'b1;
    logic       reg_wr     = 1'b0;
    logic       reg_rd     = 1'b0;
    logic [7:0] reg_addr   = 8'h00;
    logic [7:0] reg_wdata  = 8'h00;
    logic       lock_block = 1'b0;
    logic [7:0] reg_rdata;
    logic       loop_locked, tune_too_low, mult_locked;
    logic       ref_duty_fix_en, ref_cross_adjust_en, mult_en;
    logic [4:0] ref_cross_level, pump_current_code;
    logic [5:0] band_sel;
    logic [2:0] loop_filter_width;
    logic [1:0] logic_clock_ratio, oscillator_ratio_select;
    logic [1:0] loop_ratio_select;
    logic       loop_cross_en;
    logic [29:0] outs;
    int         n_mismatch = 0;
    int         num_checks = 0;
    int         cyc        = 0;
    logic [7:0] d;
    // All field outputs gathered for compact compares
    assign outs = {ref_duty_fix_en, ref_cross_adjust_en, ref_cross_level,
        mult_en, band_sel, loop_filter_width, pump_current_code,
        logic_clock_ratio, loop_cross_en, oscillator_ratio_select,
        loop_ratio_select, mult_locked};
    // Clock generator
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    // Device under test with a short settle count
    rcm_ctrl #(.SETTLE_CYC(2)) dut (.core_clk(core_clk), .srst(srst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .loop_locked(loop_locked), .tune_too_low(tune_too_low),
        .ref_duty_fix_en(ref_duty_fix_en),
        .ref_cross_adjust_en(ref_cross_adjust_en),
        .ref_cross_level(ref_cross_level), .mult_en(mult_en),
        .band_sel(band_sel), .loop_filter_width(loop_filter_width),
        .pump_current_code(pump_current_code),
        .logic_clock_ratio(logic_clock_ratio),
        .loop_cross_en(loop_cross_en),
        .oscillator_ratio_select(oscillator_ratio_select),
        .loop_ratio_select(loop_ratio_select), .mult_locked(mult_locked));
    // Analog loop partner
    rcm_loop_model u_loop (.core_clk(core_clk), .mult_en(mult_en),
        .band_sel(band_sel), .lock_block(lock_block),
        .loop_locked(loop_locked), .tune_too_low(tune_too_low));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One write pulse; returns two edges after the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    // One read pulse; data is compared once the taking edge has settled
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // Bounded wait for the lock flag to reach a level
    task automatic wait_lock(input logic v);
        for (int i = 0; i < 3000 && mult_locked !== v; i++)
        begin
            @(posedge core_clk);
            #1;
        end
        chk(mult_locked, v);
    endtask
    // Register and output reset values, unmapped offset 0x13 included
    task automatic rst_chk();
        logic [7:0] rv [5] = '{8'h5F, 8'h00, 8'h00, 8'hE7, 8'hC9};
        chk(outs, {2'h0, 5'h1F, 7'h00, 3'h7, 5'h07, 2'h3, 1'h0, 2'h2,
            2'h1, 1'h0});
        for (int i = 0; i < 5; i++)
            rd(8'h11 + i[7:0], rv[i]);
    endtask
    // Run limit
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // Main sequence
    initial
    begin
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        rst_chk();
        // Reference input fields, reserved bit kept at one, then loop tuning fields
        wr(8'h11, 8'hD0);
        chk(outs[29:23], 7'h50);
        wr(8'h11, 8'h6F);
        chk(outs[29:23], 7'h2F);
        rd(8'h11, 8'h6F);
        wr(8'h11, 8'h5F);
        chk(outs[29:23], 7'h1F);
        wr(8'h14, 8'h1F);
        chk(outs[15:8], 8'h1F);
        rd(8'h14, 8'h1F);
        // All four codes of each divider ratio field; any ratio keeps 100 MHz logic under 75 MHz
        for (int i = 0; i < 4; i++)
        begin
            d = {i[1:0], 2'h3, i[1:0], i[1:0]};
            wr(8'h15, d);
            chk(outs[7:1], {d[7:6], d[4:0]});
            rd(8'h15, d & 8'hDF);
        end
        // Status offsets ignore writes
        wr(8'h16, 8'hFF);
        wr(8'h17, 8'h3F);
        rd(8'h16, 8'h00);
        rd(8'h17, 8'h00);
        // Manual band away from and then on the lock band
        wr(8'h12, 8'hEA);
        chk(outs[22:16], 7'h6A);
        rd(8'h17, 8'h2A);
        wr(8'h12, 8'hC5);
        wait_lock(1'b1);
        rd(8'h16, 8'h80);
        // Automatic search ignores the manual field
        wr(8'h12, 8'h00);
        wait_lock(1'b0);
        wr(8'h12, 8'hBF);
        wait_lock(1'b1);
        chk(band_sel, 6'h05);
        rd(8'h17, 8'h05);
        // Loss of lock and recovery
        @(posedge core_clk);
        lock_block <= 1'b1;
        wait_lock(1'b0);
        @(posedge core_clk);
        lock_block <= 1'b0;
        wait_lock(1'b1);
        // Second reset in mid-run
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        rst_chk();
        report_and_stop();
    end
endmodule
`default_nettype wire
